// file: hcmp_pkg.sv
/*
 Package for the IP/ACH and timing header comparator: register map,
 field positions, reset value, codes and carrier structs.
 Assumes a 32-bit classic Wishbone slave and 128-byte header windows.
*/
package hcmp_pkg;
   localparam int HB = 128;
   localparam int NFLOW = 4;
   localparam int NIP = 2;
   localparam int NWORDS = 192;
   localparam int AW = 10;
   // Word indices, byte address is four times these
   localparam int W_MODE = 0;
   localparam int W_LEN = 1;
   localparam int W_UDP = 2;
   localparam int W_P2M = 3;
   localparam int W_P2K = 5;
   localparam int W_FLOW = 16;
   localparam int F_STRIDE = 12;
   localparam int F_MATCH = 0;
   localparam int F_MASK = 4;
   localparam int F_CTRL = 8;
   localparam int IP_BANK = 64;
   localparam int W_TMASK = 128;
   localparam int W_TFLOW = 130;
   localparam int T_STRIDE = 4;
   localparam int T_CTRL = 2;
   localparam int W_STATUS = 191;
   // Field positions
   localparam int MODE_LSB = 0;
   localparam int P1M_LSB = 8;
   localparam int P1K_LSB = 16;
   localparam int P1P_LSB = 24;
   localparam int P2P_LSB = 0;
   localparam int HLEN_LSB = 8;
   localparam int NXT_LSB = 16;
   localparam int FPOS_LSB = 24;
   localparam int UZ_BIT = 0;
   localparam int UF_BIT = 1;
   localparam int UPOS_LSB = 8;
   localparam int ULEN_LSB = 16;
   localparam int SIG_LSB = 24;
   localparam int FEN_BIT = 0;
   localparam int FSEL_LSB = 1;
   localparam int FPORT_LSB = 4;
   localparam int DLO_LSB = 0;
   localparam int DHI_LSB = 8;
   localparam int DPOS_LSB = 16;
   localparam int DEN_BIT = 21;
   localparam int TEN_BIT = 22;
   localparam int TPORT_LSB = 24;
   localparam int ACT_LSB = 28;
   localparam int ST_HIT_LSB = 0;
   localparam int ST_PASS_BIT = 4;
   localparam int ST_THIT_BIT = 8;
   localparam int ST_ACT_LSB = 9;
   localparam int ST_TFLOW_LSB = 12;
   // Header layout
   localparam int V4_FRAG_BYTE = 6;
   localparam int MF_BIT = 5;
   localparam int V4_DST = 4;
   localparam int V6_DST = 16;
   localparam logic [31:0] REG_RST = 32'h0000_0000;
   localparam logic [3:0] VER4 = 4'h4;
   localparam logic [3:0] VER6 = 4'h6;
   localparam logic [2:0] NXT_ETH2 = 3'h1;
   localparam logic [2:0] NXT_IP1 = 3'h2;
   localparam logic [2:0] NXT_IP2 = 3'h3;
   localparam logic [2:0] NXT_TM = 3'h5;
   localparam logic [1:0] SEL_SRC = 2'h0;
   localparam logic [1:0] SEL_DST = 2'h1;
   localparam logic [1:0] SEL_ANY = 2'h2;

   typedef enum logic [1:0] {
      HCMP_V4 = 2'h0,
      HCMP_V6 = 2'h1,
      HCMP_G32 = 2'h2,
      HCMP_G128 = 2'h3
   } hcmp_mode_t;

   typedef struct packed {
      logic [HB*8-1:0] bytes;
      logic [2:0] target;
      logic chan;
   } hcmp_hdr_t;

   typedef struct packed {
      logic comp;
      logic pass;
      logic [NFLOW-1:0] hit;
      logic [2:0] next;
      logic nxt_ok;
      logic [7:0] next_off;
      logic zero_en;
      logic fixup_en;
      logic [7:0] sum_pos;
      logic [1:0] sum_len;
      logic [4:0] sig_pos;
   } hcmp_ip_res_t;

   typedef struct packed {
      logic hit;
      logic [1:0] flow;
      logic [2:0] action;
   } hcmp_tm_res_t;
endpackage

// file: hcmp_header_comparator.sv
/*
 Two IP/UDP/ACH header comparators and the final timing header
 comparator, with their configuration reached over classic Wishbone.
 Assumes the preceding analyzer stage presents one header window per
 cycle, byte 0 at the top, with the stage code it points at.
*/
`timescale 1ns/1ps
`default_nettype none

module hcmp_header_comparator (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // Wishbone slave
   input wire logic wb_cyc,
   input wire logic wb_stb,
   input wire logic wb_we,
   input wire logic [hcmp_pkg::AW-1:0] wb_adr,
   input wire logic [3:0] wb_sel,
   input wire logic [31:0] wb_wdat,
   output logic [31:0] wb_rdat,
   output logic wb_ack,
   // Header from preceding stage
   input wire logic hdr_valid,
   input wire hcmp_pkg::hcmp_hdr_t hdr,
   // IP comparator result
   output logic ip_valid,
   output hcmp_pkg::hcmp_ip_res_t ip_res,
   // Timing comparator result
   output logic tm_valid,
   output hcmp_pkg::hcmp_tm_res_t tm_res
);
   logic [31:0] regs_q [hcmp_pkg::NWORDS];
   logic ack_q;
   logic [31:0] rdat_q;
   logic [31:0] st_q;
   logic ip_valid_q;
   logic tm_valid_q;
   hcmp_pkg::hcmp_ip_res_t ip_res_q;
   hcmp_pkg::hcmp_tm_res_t tm_res_q;
   hcmp_pkg::hcmp_ip_res_t res_c [hcmp_pkg::NIP];
   hcmp_pkg::hcmp_tm_res_t tm_c;
   logic [7:0] idx;
   logic mapped;
   logic req;
   logic is_ip;
   logic is_tm;

   function automatic logic [7:0] getb(
      input logic [hcmp_pkg::HB*8-1:0] v,
      input int i
   );
      // Bytes beyond the window read as zero
      if (i < hcmp_pkg::HB)
      begin
         return v[(hcmp_pkg::HB-1-i)*8 +: 8];
      end
      return 8'h00;
   endfunction

   function automatic logic [127:0] grab16(
      input logic [hcmp_pkg::HB*8-1:0] v,
      input int off
   );
      logic [127:0] r;
      r = '0;
      for (int i = 0; i < 16; i++)
      begin
         r[127-8*i -: 8] = getb(v, off + i);
      end
      return r;
   endfunction

   // Zero mask gives a match, so a cleared set never fails
   function automatic logic mok(
      input logic [127:0] f,
      input logic [127:0] m,
      input logic [127:0] k
   );
      return ((f ^ m) & k) == 128'h0;
   endfunction

   function automatic logic is_mapped(input int i);
      int r;
      r = 0;
      if (i == hcmp_pkg::W_STATUS)
      begin
         return 1'b1;
      end
      if (i >= hcmp_pkg::W_TMASK)
      begin
         if (i < hcmp_pkg::W_TFLOW)
         begin
            return 1'b1;
         end
         r = i - hcmp_pkg::W_TFLOW;
         return r < hcmp_pkg::NFLOW * hcmp_pkg::T_STRIDE &&
            r % hcmp_pkg::T_STRIDE <= hcmp_pkg::T_CTRL;
      end
      r = i % hcmp_pkg::IP_BANK;
      if (r <= hcmp_pkg::W_P2K + 1)
      begin
         return 1'b1;
      end
      return r >= hcmp_pkg::W_FLOW &&
         (r - hcmp_pkg::W_FLOW) % hcmp_pkg::F_STRIDE <= hcmp_pkg::F_CTRL;
   endfunction

   assign idx = wb_adr[hcmp_pkg::AW-1:2];
   assign mapped = is_mapped(int'(idx));
   assign req = wb_cyc && wb_stb && !ack_q;
   assign wb_ack = ack_q;
   assign wb_rdat = rdat_q;

   // Bus answer one cycle after the request is seen
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ack_q <= 1'b0;
      end
      else if (ce)
      begin
         ack_q <= req;
      end
   end

   // Unmapped reads return zero, status is read only
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rdat_q <= 32'h0000_0000;
      end
      else if (ce && req)
      begin
         if (int'(idx) == hcmp_pkg::W_STATUS)
         begin
            rdat_q <= st_q;
         end
         else if (mapped)
         begin
            rdat_q <= regs_q[idx];
         end
         else
         begin
            rdat_q <= 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         for (int i = 0; i < hcmp_pkg::NWORDS; i++)
         begin
            regs_q[i] <= hcmp_pkg::REG_RST;
         end
      end
      else if (ce && req && wb_we && mapped &&
         int'(idx) != hcmp_pkg::W_STATUS)
      begin
         for (int b = 0; b < 4; b++)
         begin
            if (wb_sel[b])
            begin
               regs_q[idx][8*b +: 8] <= wb_wdat[8*b +: 8];
            end
         end
      end
   end

   // Each bank is a full comparator; the prior stage picks one
   for (genvar g = 0; g < hcmp_pkg::NIP; g++)
   begin : g_ip
      localparam int B = g * hcmp_pkg::IP_BANK;
      logic [31:0] w_mode;
      logic [31:0] w_len;
      logic [31:0] w_udp;
      hcmp_pkg::hcmp_mode_t mode;
      logic [7:0] b1;
      logic [63:0] p2m;
      logic [63:0] p2k;
      logic [127:0] p2f;
      logic [127:0] fa;
      logic [127:0] fb;
      logic ver_ok;
      logic frag_ok;
      logic pass;
      logic [hcmp_pkg::NFLOW-1:0] hit;

      assign w_mode = regs_q[B + hcmp_pkg::W_MODE];
      assign w_len = regs_q[B + hcmp_pkg::W_LEN];
      assign w_udp = regs_q[B + hcmp_pkg::W_UDP];
      assign mode = hcmp_pkg::hcmp_mode_t'(w_mode[hcmp_pkg::MODE_LSB +: 2]);
      assign b1 = getb(hdr.bytes, int'(w_mode[hcmp_pkg::P1P_LSB +: 5]));
      assign p2m = {regs_q[B + hcmp_pkg::W_P2M + 1],
         regs_q[B + hcmp_pkg::W_P2M]};
      assign p2k = {regs_q[B + hcmp_pkg::W_P2K + 1],
         regs_q[B + hcmp_pkg::W_P2K]};
      assign p2f = grab16(hdr.bytes, int'(w_len[hcmp_pkg::P2P_LSB +: 7]));
      // Flow field starts at programmed offset
      assign fa = grab16(hdr.bytes,
         int'(w_len[hcmp_pkg::FPOS_LSB +: 5]));
      assign fb = grab16(hdr.bytes,
         int'(w_len[hcmp_pkg::FPOS_LSB +: 5]) + hcmp_pkg::V6_DST);

      always_comb
      begin
         ver_ok = 1'b1;
         frag_ok = 1'b1;
         case (mode)
            hcmp_pkg::HCMP_V4:
            begin
               ver_ok = hdr.bytes[hcmp_pkg::HB*8-1 -: 4] ==
                  hcmp_pkg::VER4;
               frag_ok = getb(hdr.bytes, hcmp_pkg::V4_FRAG_BYTE + 1) ==
                  8'h00 &&
                  getb(hdr.bytes, hcmp_pkg::V4_FRAG_BYTE)
                  [hcmp_pkg::MF_BIT:0] == 6'h00;
            end
            hcmp_pkg::HCMP_V6:
            begin
               ver_ok = hdr.bytes[hcmp_pkg::HB*8-1 -: 4] ==
                  hcmp_pkg::VER6;
            end
            default:
            begin
               ver_ok = 1'b1;
            end
         endcase
      end

      assign pass = ver_ok && frag_ok &&
         ((b1 ^ w_mode[hcmp_pkg::P1M_LSB +: 8]) &
         w_mode[hcmp_pkg::P1K_LSB +: 8]) == 8'h00 &&
         mok({p2f[127:64], 64'h0}, {p2m, 64'h0},
         {p2k, 64'h0});

      always_comb
      begin
         logic [127:0] m;
         logic [127:0] k;
         logic [127:0] km;
         logic [127:0] src;
         logic [127:0] dst;
         logic [31:0] c;
         logic sok;
         logic dok;
         logic aok;
         int fb0;
         m = '0;
         k = '0;
         km = '0;
         src = '0;
         dst = '0;
         c = '0;
         sok = 1'b0;
         dok = 1'b0;
         aok = 1'b0;
         fb0 = 0;
         hit = '0;
         for (int f = 0; f < hcmp_pkg::NFLOW; f++)
         begin
            fb0 = B + hcmp_pkg::W_FLOW + f * hcmp_pkg::F_STRIDE;
            for (int j = 0; j < 4; j++)
            begin
               m[32*j +: 32] = regs_q[fb0 + hcmp_pkg::F_MATCH + j];
               k[32*j +: 32] = regs_q[fb0 + hcmp_pkg::F_MASK + j];
            end
            c = regs_q[fb0 + hcmp_pkg::F_CTRL];
            // 32-bit forms use only the upper match word
            km = {k[127:96], 96'h0};
            src = {fa[127:96], 96'h0};
            dst = {fa[95:64], 96'h0}; // IPv4 dest follows source
            if (mode == hcmp_pkg::HCMP_V6 || mode == hcmp_pkg::HCMP_G128)
            begin
               km = k;
               src = fa;
               dst = fb;
            end
            sok = mok(src, m, km);
            dok = mok(dst, m, km);
            if (mode == hcmp_pkg::HCMP_G32 || mode == hcmp_pkg::HCMP_G128)
            begin
               aok = sok;
            end
            else
            begin
               case (c[hcmp_pkg::FSEL_LSB +: 2])
                  hcmp_pkg::SEL_SRC: aok = sok;
                  hcmp_pkg::SEL_DST: aok = dok;
                  hcmp_pkg::SEL_ANY: aok = sok || dok;
                  default: aok = 1'b0;
               endcase
            end
            hit[f] = pass && aok && c[hcmp_pkg::FEN_BIT] &&
               c[hcmp_pkg::FPORT_LSB + int'(hdr.chan)];
         end
      end

      always_comb
      begin
         res_c[g].comp = 1'(g);
         res_c[g].pass = pass;
         res_c[g].hit = hit;
         res_c[g].next = w_len[hcmp_pkg::NXT_LSB +: 3];
         case (w_len[hcmp_pkg::NXT_LSB +: 3])
            hcmp_pkg::NXT_ETH2,
            hcmp_pkg::NXT_IP1,
            hcmp_pkg::NXT_IP2,
            hcmp_pkg::NXT_TM: res_c[g].nxt_ok = 1'b1;
            default: res_c[g].nxt_ok = 1'b0;
         endcase
         // Software sets the length; no header parsing here
         res_c[g].next_off = w_len[hcmp_pkg::HLEN_LSB +: 8];
         res_c[g].zero_en = w_udp[hcmp_pkg::UZ_BIT];
         res_c[g].fixup_en = w_udp[hcmp_pkg::UF_BIT];
         res_c[g].sum_pos = w_udp[hcmp_pkg::UPOS_LSB +: 8];
         res_c[g].sum_len = w_udp[hcmp_pkg::ULEN_LSB +: 2];
         res_c[g].sig_pos = w_udp[hcmp_pkg::SIG_LSB +: 5];
      end
   end

   // Lowest numbered matching flow wins
   always_comb
   begin
      logic [63:0] h64;
      logic [63:0] tk;
      logic [63:0] tm;
      logic [31:0] c;
      logic [7:0] d;
      logic rng;
      logic [127:0] h128;
      int tb;
      h128 = grab16(hdr.bytes, 0);
      h64 = h128[127:64];
      tk = {regs_q[hcmp_pkg::W_TMASK + 1], regs_q[hcmp_pkg::W_TMASK]};
      tm = '0;
      c = '0;
      d = '0;
      rng = 1'b0;
      tb = 0;
      tm_c = '0;
      for (int f = hcmp_pkg::NFLOW - 1; f >= 0; f--)
      begin
         tb = hcmp_pkg::W_TFLOW + f * hcmp_pkg::T_STRIDE;
         tm = {regs_q[tb + 1], regs_q[tb]};
         c = regs_q[tb + hcmp_pkg::T_CTRL];
         d = getb(hdr.bytes, int'(c[hcmp_pkg::DPOS_LSB +: 5]));
         rng = !c[hcmp_pkg::DEN_BIT] ||
            (d >= c[hcmp_pkg::DLO_LSB +: 8] &&
            d <= c[hcmp_pkg::DHI_LSB +: 8]);
         // OAM flows clear the lower mask half to use four bytes
         if (c[hcmp_pkg::TEN_BIT] && rng &&
            c[hcmp_pkg::TPORT_LSB + int'(hdr.chan)] &&
            mok({h64, 64'h0}, {tm, 64'h0},
            {tk, 64'h0}))
         begin
            tm_c.hit = 1'b1;
            tm_c.flow = 2'(f);
            tm_c.action = c[hcmp_pkg::ACT_LSB +: 3];
         end
      end
   end

   assign is_ip = hdr_valid && (hdr.target == hcmp_pkg::NXT_IP1 ||
      hdr.target == hcmp_pkg::NXT_IP2);
   assign is_tm = hdr_valid && hdr.target == hcmp_pkg::NXT_TM;

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ip_valid_q <= 1'b0;
         ip_res_q <= '0;
      end
      else if (ce)
      begin
         ip_valid_q <= is_ip;
         if (is_ip)
         begin
            ip_res_q <= res_c[hdr.target == hcmp_pkg::NXT_IP2];
         end
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         tm_valid_q <= 1'b0;
         tm_res_q <= '0;
      end
      else if (ce)
      begin
         tm_valid_q <= is_tm;
         if (is_tm)
         begin
            tm_res_q <= tm_c;
         end
      end
   end

   // Status holds the last result of each stage
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         st_q <= 32'h0000_0000;
      end
      else if (ce)
      begin
         if (ip_valid_q)
         begin
            st_q[hcmp_pkg::ST_HIT_LSB +: hcmp_pkg::NFLOW] <= ip_res_q.hit;
            st_q[hcmp_pkg::ST_PASS_BIT] <= ip_res_q.pass;
         end
         if (tm_valid_q)
         begin
            st_q[hcmp_pkg::ST_THIT_BIT] <= tm_res_q.hit;
            st_q[hcmp_pkg::ST_ACT_LSB +: 3] <= tm_res_q.action;
            st_q[hcmp_pkg::ST_TFLOW_LSB +: 2] <= tm_res_q.flow;
         end
      end
   end

   assign ip_valid = ip_valid_q;
   assign ip_res = ip_res_q;
   assign tm_valid = tm_valid_q;
   assign tm_res = tm_res_q;
endmodule

`default_nettype wire

// file: hcmp_prev_stage.sv
/*
 Model of the preceding analyzer stage feeding header windows.
 Assumes the bench asks for one header per cycle through go.
*/
`timescale 1ns/1ps
`default_nettype none

module hcmp_prev_stage (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Request from bench
   input wire logic go,
   input wire logic [hcmp_pkg::HB*8-1:0] win,
   input wire logic [2:0] tgt,
   input wire logic chn,
   // Header to comparator
   output logic hdr_valid,
   output hcmp_pkg::hcmp_hdr_t hdr
);
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         hdr_valid <= 1'b0;
         hdr <= '0;
      end
      else
      begin
         hdr_valid <= go;
         // Load window, target and channel on a request
         if (go)
            hdr <= '{win, tgt, chn};
         // Idle window flips each cycle; the stale header returns every other cycle
         else
            hdr.bytes <= ~hdr.bytes;
      end
   end
endmodule

`default_nettype wire

// file: hcmp_header_comparator_assertions.sv
/*
 Port checker for the header comparator.
 Assumes ce is high whenever answers are expected.
*/
`timescale 1ns/1ps
`default_nettype none

module hcmp_header_comparator_assertions (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // Bus
   input wire logic wb_cyc,
   input wire logic wb_stb,
   input wire logic wb_ack,
   // Header and results
   input wire logic hdr_valid,
   input wire hcmp_pkg::hcmp_hdr_t hdr,
   input wire logic ip_valid,
   input wire hcmp_pkg::hcmp_ip_res_t ip_res,
   input wire logic tm_valid,
   input wire hcmp_pkg::hcmp_tm_res_t tm_res
);
   logic ip_req;
   logic tm_req;
   logic tgt0;
   assign ip_req = ce && hdr_valid && (hdr.target == hcmp_pkg::NXT_IP1
      || hdr.target == hcmp_pkg::NXT_IP2);
   assign tm_req = ce && hdr_valid && hdr.target == hcmp_pkg::NXT_TM;
   assign tgt0 = hdr.target[0];

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   ack_pulse_a: assert property (ce && wb_ack |=> !wb_ack)
      else $error("ack longer than one cycle");
   ack_answer_a: assert property
      (ce && wb_cyc && wb_stb && !wb_ack |=> wb_ack)
      else $error("bus request not answered");
   ip_answer_a: assert property (ip_req |=> ip_valid)
      else $error("ip result missing");
   ip_cause_a: assert property (ip_valid |-> $past(ip_req))
      else $error("ip result without header");
   tm_answer_a: assert property (tm_req |=> tm_valid)
      else $error("timing result missing");
   ip_comp_a: assert property
      (ip_valid |-> ip_res.comp == $past(tgt0))
      else $error("wrong comparator bank");
   ip_hold_a: assert property (!ip_valid |-> $stable(ip_res))
      else $error("ip result changed while idle");
   tm_hold_a: assert property (!tm_valid |-> $stable(tm_res))
      else $error("timing result changed while idle");
   next_code_a: assert property (ip_valid |-> ip_res.nxt_ok ==
      (ip_res.next inside {3'h1, 3'h2, 3'h3, 3'h5}))
      else $error("next code flag wrong");
   hit_pass_a: assert property
      (ip_valid && (|ip_res.hit) |-> ip_res.pass)
      else $error("flow hit without pass");
endmodule

bind hcmp_header_comparator hcmp_header_comparator_assertions u_chk (
   .clk(clk), .nrst(nrst), .ce(ce), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
   .wb_ack(wb_ack), .hdr_valid(hdr_valid), .hdr(hdr),
   .ip_valid(ip_valid), .ip_res(ip_res), .tm_valid(tm_valid),
   .tm_res(tm_res)
);

`default_nettype wire

// file: hcmp_header_comparator_bench.sv
/*
 Self-checking bench for the header comparator.
 Assumes the stage model in front; ce is held high except during the frozen-block check.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) \
   begin \
      comparisons++; \
      if ((a) !== (b)) \
      begin \
         n_fail++; \
         $display("Error %0t: got %h want %h", $time, a, b); \
      end \
   end

module hcmp_header_comparator_bench;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic ce = 1'b1;
   logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
   logic [hcmp_pkg::AW-1:0] wb_adr = '0;
   logic [3:0] wb_sel = 4'hF;
   logic [31:0] wb_wdat = 32'h0, wb_rdat, er;
   logic wb_ack, hdr_valid, ip_valid, tm_valid;
   logic go = 1'b0, chn = 1'b0;
   logic [2:0] tgt = 3'h0;
   logic [hcmp_pkg::HB*8-1:0] win = '0, w;
   logic [31:0] rs = 32'hEE25_5993, fa, fb, fc;
   logic [6:0] et;
   logic [7:0] ctl [4] = '{8'h11, 8'h33, 8'h35, 8'h34};
   hcmp_pkg::hcmp_hdr_t hdr;
   hcmp_pkg::hcmp_ip_res_t ip_res, ei, eq;
   hcmp_pkg::hcmp_tm_res_t tm_res;
   logic [31:0] rq [$];
   hcmp_pkg::hcmp_ip_res_t iq [$];
   logic [6:0] tq [$];
   int n_fail = 0, comparisons = 0;

   always #2 clk = ~clk;

   hcmp_prev_stage prev (.clk(clk), .nrst(nrst), .go(go), .win(win),
      .tgt(tgt), .chn(chn), .hdr_valid(hdr_valid), .hdr(hdr));

   hcmp_header_comparator uut (.clk(clk), .nrst(nrst), .ce(ce),
      .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
      .wb_sel(wb_sel), .wb_wdat(wb_wdat), .wb_rdat(wb_rdat),
      .wb_ack(wb_ack), .hdr_valid(hdr_valid), .hdr(hdr),
      .ip_valid(ip_valid), .ip_res(ip_res), .tm_valid(tm_valid),
      .tm_res(tm_res));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic stop_test();
      if (n_fail == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic wbx(input logic we, input int idx, input logic [31:0] d,
      input logic [3:0] s);
      int n;
      logic [31:0] a;
      a = idx * 4;
      @(posedge clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a[hcmp_pkg::AW-1:0];
      wb_sel <= s;
      wb_wdat <= d;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (wb_ack !== 1'b1 && n < 50);
      if (n >= 50)
         n_fail++;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask

   task automatic wr(input int idx, input logic [31:0] d);
      wbx(1'b1, idx, d, 4'hF);
   endtask

   task automatic rd(input int idx, input logic [31:0] e);
      rq.push_back(e);
      wbx(1'b0, idx, 32'h0, 4'hF);
   endtask

   task automatic fill();
      for (int i = 0; i < hcmp_pkg::HB / 4; i++)
      begin
         rs = lfsr(rs);
         w[i*32 +: 32] = rs;
      end
   endtask

   task automatic put(input int k, input logic [7:0] b);
      w[hcmp_pkg::HB*8-1-8*k -: 8] = b;
   endtask

   task automatic put32(input int k, input logic [31:0] v);
      for (int j = 0; j < 4; j++)
         put(k + j, v[31-8*j -: 8]);
   endtask

   task automatic snd(input logic [2:0] t, input logic c);
      @(posedge clk);
      go <= 1'b1;
      tgt <= t;
      chn <= c;
      win <= w;
   endtask

   task automatic ip(input logic [2:0] t, input logic c, p,
      input logic [3:0] h);
      if (t == hcmp_pkg::NXT_IP1)
         ei = '{1'b0, p, h, 3'h5, 1'b1, 8'h14, 1'b1, 1'b0, 8'h1A, 2'h2,
            5'h0C};
      else
         ei = '{1'b1, p, h, 3'h4, 1'b0, 8'h08, 1'b0, 1'b1, 8'h00, 2'h0,
            5'h00};
      iq.push_back(ei);
      snd(t, c);
   endtask

   task automatic v4(input logic [3:0] v, input logic [7:0] b6, b7, pr,
      input logic [31:0] s, d);
      fill();
      put(0, {v, 4'h5});
      put(6, b6);
      put(7, b7);
      put(9, pr);
      put32(12, s);
      put32(16, d);
   endtask

   task automatic tmh(input logic [7:0] b0, dom, input logic [6:0] e);
      fill();
      put(0, b0);
      put(4, dom);
      tq.push_back(e);
      snd(hcmp_pkg::NXT_TM, rs[0]);
   endtask

   // Results are matched in arrival order against the notes
   always @(posedge clk)
   begin
      if (wb_ack && !wb_we)
      begin
         er = rq.pop_front();
         `CHK(wb_rdat, er)
      end
      if (ip_valid)
      begin
         eq = iq.pop_front();
         `CHK(ip_res, eq)
      end
      if (tm_valid)
      begin
         et = tq.pop_front();
         if (et[6])
            `CHK(tm_res, et[5:0])
         else
            `CHK(tm_res.hit, et[5])
      end
   end

   initial
   begin
      repeat (20000) @(posedge clk);
      n_fail++;
      stop_test();
   end

   initial
   begin
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      fa = lfsr(rs);
      fb = lfsr(fa);
      fc = lfsr(fb);
      wr(0, 32'h09FF_1100);
      wr(1, 32'h0C05_1400);
      wr(2, 32'h0C02_1A01);
      wr(3, fc);
      wr(4, ~fc);
      for (int f = 0; f < 4; f++)
      begin
         for (int j = 0; j < 4; j++)
         begin
            rs = lfsr(rs);
            wr(16 + 12 * f + j, (j == 3) ? ((f == 1) ? fb : fa) : rs);
            if (f < 3)
               wr(20 + 12 * f + j, 32'hFFFF_FFFF);
         end
         wr(24 + 12 * f, {24'h0, ctl[f]});
      end
      wr(64, 32'h0000_AA02);
      wr(65, 32'h0404_0800);
      wr(66, 32'h0000_0002);
      wr(67, fc);
      wr(68, 32'h5A00_0000);
      wr(70, 32'hFF00_0000);
      for (int j = 0; j < 4; j++)
      begin
         wr(80 + j, fc);
         wr(84 + j, 32'hFFFF_0000);
      end
      wr(88, 32'h0000_0037);
      wr(129, 32'hFF00_0000);
      wr(130, fc);
      wr(131, 32'h0100_0000);
      wr(132, 32'h3364_0503);
      wr(135, 32'h0100_0000);
      wr(136, 32'h5340_0000);
      rd(0, 32'h09FF_1100);
      rd(66, 32'h0000_0002);
      wr(150, fc);
      rd(150, 32'h0);
      wbx(1'b1, 3, 32'hFFFF_FFFF, 4'h2);
      rd(3, {fc[31:16], 8'hFF, fc[7:0]});
      // Headers go back to back, one per cycle
      v4(4, 8'h40, 8'h00, 8'h11, fa, fb);
      ip(2, 1'b0, 1'b1, 4'h7);
      v4(4, 8'h00, 8'h00, 8'h11, fa, fb);
      ip(2, 1'b1, 1'b1, 4'h6);
      v4(4, 8'h00, 8'h00, 8'h11, ~fa, fb);
      ip(2, 1'b0, 1'b1, 4'h2);
      v4(4, 8'h00, 8'h00, 8'h11, fb, fa);
      ip(2, 1'b1, 1'b1, 4'h4);
      v4(6, 8'h00, 8'h00, 8'h11, fa, fb);
      ip(2, 1'b0, 1'b0, 4'h0);
      v4(4, 8'h20, 8'h00, 8'h11, fa, fb);
      ip(2, 1'b0, 1'b0, 4'h0);
      v4(4, 8'h00, 8'h01, 8'h11, fa, fb);
      ip(2, 1'b0, 1'b0, 4'h0);
      v4(4, 8'h00, 8'h00, 8'h06, fa, fb);
      ip(2, 1'b0, 1'b0, 4'h0);
      fill();
      put(0, 8'h5A);
      put32(4, {fc[31:16], ~fc[15:0]});
      ip(3, 1'b1, 1'b1, 4'h1);
      fill();
      put(0, 8'h5B);
      put32(4, fc);
      ip(3, 1'b0, 1'b0, 4'h0);
      fill();
      put(0, 8'h5A);
      put32(4, fc ^ 32'h0001_0000);
      ip(3, 1'b1, 1'b1, 4'h0);
      for (int d = 2; d <= 6; d++)
         tmh(8'h01, d[7:0], (d >= 3 && d <= 5) ? 7'h63 : 7'h6D);
      @(posedge clk);
      go <= 1'b0;
      wr(191, 32'hFFFF_FFFF);
      rd(191, 32'h0000_1B10);
      tmh(8'h02, 8'h04, 7'h00);
      @(posedge clk);
      go <= 1'b0;
      // Frozen block must ignore a header; a stray result pops nothing
      repeat (3) @(posedge clk);
      ce <= 1'b0;
      v4(4, 8'h40, 8'h00, 8'h11, fa, fb);
      snd(2, 1'b0);
      @(posedge clk);
      go <= 1'b0;
      repeat (3) @(posedge clk);
      ce <= 1'b1;
      repeat (5) @(posedge clk);
      `CHK(rq.size() + iq.size() + tq.size(), 0)
      stop_test();
   end
endmodule

`default_nettype wire
